// File: tb/stap_assertions.sv
// Checker for the scan test access port, on top-level ports only.
// Assumes the bench binds it to stap_top.
`timescale 1ns/1ps
module stap_chk (
    input wire logic clk_sys_in, // System clock
    input wire logic rst_b_in, // System reset
    input wire logic tck_in, // Test clock
    input wire logic test_rst_b_in, // Test reset
    input wire logic tms_in, // Mode select
    input wire logic tdo_out, // Data out
    input wire logic tdo_oe_out, // Data out enable
    input wire logic emu_a_in, // Pin A level
    input wire logic emulator_pin_b_or_disable_in, // Pin B level
    input wire logic emu_a_oe_out, // Pin A enable
    input wire logic emulator_pin_b_or_disable_oe_out, // Pin B enable
    input wire logic scan_mode_out, // Scan control
    input wire logic outputs_off_out, // Drivers off
    input wire logic scan_active_out, // Out of reset state
    input wire logic instr_strobe_out, // New instruction
    input wire logic user_strobe_out // New user word
);
    logic off_cond;
    assign off_cond = !test_rst_b_in && emu_a_in
        && !emulator_pin_b_or_disable_in;

    // Test clock high 32 ns: two samples 20 ns apart see no fall between
    a_tdo_falls_only: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in || !test_rst_b_in)
        tck_in && $past(tck_in) |-> $stable(tdo_out) && $stable(tdo_oe_out))
        else $error("tdo changed while test clock high");
    // Every shift state is entered with select low
    a_oe_needs_shift: assert property (
        @(posedge tck_in) disable iff (!test_rst_b_in)
        tdo_oe_out |-> !$past(tms_in))
        else $error("tdo driven outside a shift state");
    a_oe_leaves_exit: assert property (
        @(posedge tck_in) disable iff (!test_rst_b_in)
        tdo_oe_out && tms_in |=> !tdo_oe_out)
        else $error("tdo still driven after leaving shift");
    a_float_functional: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        !test_rst_b_in |-> !tdo_oe_out)
        else $error("tdo driven in functional mode");
    a_off_floats_tdo: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        outputs_off_out |-> !tdo_oe_out)
        else $error("tdo driven while outputs disabled");
    a_off_sets: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        off_cond [*4] |-> outputs_off_out)
        else $error("disable condition not followed");
    a_off_clears: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!off_cond) [*4] |-> !outputs_off_out)
        else $error("outputs disabled without condition");
    a_scan_follows: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        test_rst_b_in [*4] |-> scan_mode_out)
        else $error("scan mode missing with test reset high");
    a_functional_idle: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        (!test_rst_b_in) [*5] |-> !scan_mode_out && !scan_active_out)
        else $error("scan logic active with test reset low");
    a_emu_quiet_off: assert property (
        @(posedge clk_sys_in) disable iff (!rst_b_in)
        outputs_off_out |=> !emu_a_oe_out
            && !emulator_pin_b_or_disable_oe_out)
        else $error("emulator pin driven while outputs disabled");

    c_instr_update: cover property (@(posedge clk_sys_in) instr_strobe_out);
    c_user_update: cover property (@(posedge clk_sys_in) user_strobe_out);
    c_outputs_off: cover property (@(posedge clk_sys_in) outputs_off_out);
    c_shifting: cover property (@(posedge tck_in) tdo_oe_out);
endmodule

// File: tb/stap_ctl_model.sv
// Model of the external scan controller on the test port pins.
// Assumes tasks are called one at a time; the test clock rests low between.
`timescale 1ns/1ps
module stap_ctl_model (
    output logic tck_out, // Test clock
    output logic tms_out, // Mode select
    output logic tdi_out, // Data to device
    output logic test_rst_b_out, // Test reset, low = functional
    input wire logic tdo_in, // Data from device
    input wire logic tdo_oe_in // Device drives data out
);
    initial begin
        tck_out = 1'b0;
        tms_out = 1'b1;
        tdi_out = 1'b1;
        test_rst_b_out = 1'b0;
    end

    task automatic set_trst(input logic v);
        test_rst_b_out <= v;
    endtask

    // One bit per clock; data out read at the rising edge, x when floating
    task automatic frame(input logic [31:0] tms_v, input logic [31:0] tdi_v,
                         input int n, output logic [31:0] tdo_v);
        tdo_v = {32{1'bx}};
        #3;
        for (int i = 0; i < n; i++) begin
            tms_out = tms_v[i];
            tdi_out = tdi_v[i];
            #16;
            tck_out = 1'b1;
            tdo_v[i] = tdo_oe_in ? tdo_in : 1'bx;
            #32;
            tck_out = 1'b0;
            #16;
        end
        // Released lines return to their pull-up level
        tms_out = 1'b1;
        tdi_out = 1'b1;
    endtask
endmodule

// File: tb/tb_scan_test_access_port.sv
// Self-checking bench for the scan test access port.
// Assumes stap_top, the checker and the controller model are compiled first.
`timescale 1ns/1ps
module tb_scan_test_access_port;
    import stap_pkg::*;
    logic clk_sys_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic emu_a_ext = 1'b1;
    logic emu_b_ext = 1'b1;
    logic emu_a_drv = 1'b0;
    logic emu_b_drv = 1'b0;
    logic tck, trst_b, tms, tdi, tdo, tdo_oe, emu_a_pin, emu_b_pin;
    logic emu_a_o, emu_a_oe, emu_b_o, emu_b_oe;
    logic scan_mode, off, ev_a, ev_b, active, istb, ustb;
    logic [STAP_IR_W-1:0] instr;
    logic [STAP_USER_W-1:0] user_word;
    logic [31:0] t;
    int n_errors = 0;
    int samples_checked = 0;

    // Pulled-up pins: low only where some party enables its driver
    assign emu_a_pin = emu_a_oe ? emu_a_o : emu_a_ext;
    assign emu_b_pin = emu_b_oe ? emu_b_o : emu_b_ext;

    stap_ctl_model u_ctl (
        .tck_out(tck), .tms_out(tms), .tdi_out(tdi),
        .test_rst_b_out(trst_b), .tdo_in(tdo), .tdo_oe_in(tdo_oe)
    );
    stap_top uut (
        .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tck_in(tck),
        .test_rst_b_in(trst_b), .tms_in(tms), .tdi_in(tdi),
        .tdo_out(tdo), .tdo_oe_out(tdo_oe), .emu_a_in(emu_a_pin),
        .emu_a_out(emu_a_o), .emu_a_oe_out(emu_a_oe),
        .emulator_pin_b_or_disable_in(emu_b_pin),
        .emulator_pin_b_or_disable_out(emu_b_o),
        .emulator_pin_b_or_disable_oe_out(emu_b_oe),
        .emu_a_drive_in(emu_a_drv), .emu_b_drive_in(emu_b_drv),
        .scan_mode_out(scan_mode), .outputs_off_out(off),
        .emu_a_event_out(ev_a), .emu_b_event_out(ev_b),
        .scan_active_out(active), .instr_out(instr),
        .instr_strobe_out(istb), .user_word_out(user_word),
        .user_strobe_out(ustb)
    );

    always #10 clk_sys_in = ~clk_sys_in;

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic give_verdict();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic settle(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask

    task automatic wait_pulse(input bit user);
        int k;
        for (k = 0; k < 40; k++) begin
            @(negedge clk_sys_in);
            if ((user ? ustb : istb) === 1'b1) break;
        end
        check(k < 40, 1'b1);
    endtask

    // From idle: select-DR, select-IR, capture, 4 shifts, exit, update, idle
    task automatic ir_scan(input logic [3:0] code, output logic [3:0] cap);
        u_ctl.frame(32'h00000183, {24'hFFFFFF, code, 4'hF}, 10, t);
        cap = t[7:4];
        check({t[9:8], t[3:0]}, {6{1'bx}});
    endtask

    task automatic dr_scan(input logic [15:0] d, output logic [15:0] q);
        u_ctl.frame(32'h000C0001, {13'h1FFF, d, 3'h7}, 21, t);
        q = t[18:3];
        check({t[20:19], t[2:0]}, {5{1'bx}});
    endtask

    // Same user scan, parked in pause halfway: output floats there
    task automatic dr_pause(input logic [15:0] d, output logic [15:0] q);
        u_ctl.frame(32'h00C02401, {9'h1FF, d[15:8], 4'hF, d[7:0], 3'h7},
                    25, t);
        q = {t[22:15], t[10:3]};
        check({t[24:23], t[14:11], t[2:0]}, {9{1'bx}});
    endtask

    task automatic t_functional();
        logic [3:0] cap;
        ir_scan(STAP_IR_USER, cap);
        settle(10);
        check(cap, 4'hX);
        check(instr, STAP_IR_BYPASS);
        check({scan_mode, active}, 2'h0);
    endtask

    task automatic t_handover();
        @(posedge clk_sys_in);
        u_ctl.set_trst(1'b1);
        settle(6);
        check(scan_mode, 1'b1);
        u_ctl.frame(32'h0, 32'hFFFFFFFF, 1, t);
        settle(6);
        check(active, 1'b1);
        u_ctl.frame(32'h1F, 32'hFFFFFFFF, 5, t);
        settle(6);
        check(active, 1'b0);
        u_ctl.frame(32'h0, 32'hFFFFFFFF, 1, t);
    endtask

    task automatic t_user();
        logic [3:0] cap;
        logic [15:0] q;
        ir_scan(STAP_IR_USER, cap);
        check(cap, STAP_IR_CAPTURE);
        wait_pulse(1'b0);
        check(instr, STAP_IR_USER);
        dr_scan(16'hA5C3, q);
        check(q, 16'h0000);
        wait_pulse(1'b1);
        check(user_word, 16'hA5C3);
        dr_scan(16'h3C5A, q);
        check(q, 16'hA5C3);
        wait_pulse(1'b1);
        check(user_word, 16'h3C5A);
        dr_pause(16'h5AA5, q);
        check(q, 16'h3C5A);
        wait_pulse(1'b1);
        check(user_word, 16'h5AA5);
    endtask

    // Unlisted code falls back to the one-bit bypass path
    task automatic t_bypass();
        logic [3:0] cap;
        logic [15:0] q;
        ir_scan(4'h3, cap);
        wait_pulse(1'b0);
        check(instr, 4'h3);
        dr_scan(16'h96E1, q);
        check(q, 16'h2DC2);
    endtask

    task automatic t_emu();
        @(posedge clk_sys_in);
        emu_b_ext <= 1'b0;
        emu_a_drv <= 1'b1;
        settle(6);
        check({off, ev_a, ev_b, emu_a_oe}, 4'h7);
        check({emu_a_o, emu_b_o}, 2'h0);
    endtask

    task automatic t_off();
        @(posedge clk_sys_in);
        emu_b_drv <= 1'b1;
        u_ctl.set_trst(1'b0);
        settle(12);
        check(off, 1'b1);
        check({emu_a_oe, emu_b_oe, tdo_oe}, 3'h0);
        @(posedge clk_sys_in);
        emu_a_ext <= 1'b0;
        settle(6);
        check(off, 1'b0);
    endtask

    initial begin
        repeat (5) @(posedge clk_sys_in);
        rst_b_in <= 1'b1;
        settle(3);
        t_functional();
        t_handover();
        t_user();
        t_bypass();
        t_emu();
        t_off();
        give_verdict();
    end

    initial begin
        #400000;
        n_errors++;
        give_verdict();
    end
endmodule

bind stap_top stap_chk u_chk (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .tck_in(tck_in),
    .test_rst_b_in(test_rst_b_in), .tms_in(tms_in), .tdo_out(tdo_out),
    .tdo_oe_out(tdo_oe_out), .emu_a_in(emu_a_in),
    .emulator_pin_b_or_disable_in(emulator_pin_b_or_disable_in),
    .emu_a_oe_out(emu_a_oe_out),
    .emulator_pin_b_or_disable_oe_out(emulator_pin_b_or_disable_oe_out),
    .scan_mode_out(scan_mode_out), .outputs_off_out(outputs_off_out),
    .scan_active_out(scan_active_out), .instr_strobe_out(instr_strobe_out),
    .user_strobe_out(user_strobe_out)
);

// File: verilog/stap_pkg.sv
// Constants, instruction codes and state type of the scan test access port.
// Assumes a single IEEE 1149.1 port clocked by the controller's test clock.
//
// What this block does
// [RULE1] Controller supplies a free-running test clock, 50% duty cycle; the bench model runs it only during a frame.
// [RULE2] Mode select is sampled into the state controller on rising test clock.
// [RULE3] Data input enters the selected instruction or data register on rising edge.
// [RULE4] Selected register shifts out on data output, changing only on falling edges.
// [RULE5] Data output floats except while a register shift is in progress.
// [RULE6] Data output floats whenever the output-disable condition is active.
// [RULE7] Test reset high hands device control to the scan system.
// [RULE8] Test reset low means functional mode; test clock, select, data ignored.
// [RULE9] Disable needs test reset low, emulator pin A high, shared pin B low.
// [RULE10] Active disable puts every output driver of the device into high impedance.
// [RULE11] Standard sixteen-state controller, held in its reset state while test reset low.
package stap_pkg;

    localparam int STAP_IR_W = 4;
    localparam int STAP_USER_W = 16;
    localparam int STAP_SYNC_W = 6;

    // Instruction codes; any code other than the user register selects bypass
    localparam logic [STAP_IR_W-1:0] STAP_IR_BYPASS = 4'hF;
    localparam logic [STAP_IR_W-1:0] STAP_IR_USER = 4'h8;
    // Fixed capture pattern of the instruction register, low bits 01
    localparam logic [STAP_IR_W-1:0] STAP_IR_CAPTURE = 4'h1;

    // Bit positions inside the system-side synchroniser vector
    localparam int STAP_SY_IR_TGL = 0;
    localparam int STAP_SY_DR_TGL = 1;
    localparam int STAP_SY_ACTIVE = 2;
    localparam int STAP_SY_TRST = 3;
    localparam int STAP_SY_EMU_A = 4;
    localparam int STAP_SY_EMU_B = 5;

    typedef enum logic [3:0] {
        STAP_TLR,
        STAP_RTI,
        STAP_SEL_DR,
        STAP_CAP_DR,
        STAP_SH_DR,
        STAP_EX1_DR,
        STAP_PAU_DR,
        STAP_EX2_DR,
        STAP_UPD_DR,
        STAP_SEL_IR,
        STAP_CAP_IR,
        STAP_SH_IR,
        STAP_EX1_IR,
        STAP_PAU_IR,
        STAP_EX2_IR,
        STAP_UPD_IR
    } stap_state_t;

endpackage

// File: verilog/stap_shreg.sv
// Capture and shift register used for the instruction and user data paths.
// Assumes capture and shift are never requested in the same cycle.
`timescale 1ns/1ps
module stap_shreg #(
    parameter int W = 4
) (
    input wire logic clk_in,              // Test clock
    input wire logic rst_b_in,            // Async reset, active low
    input wire logic capture_in,          // Load parallel value
    input wire logic shift_in,            // Shift one place toward bit 0
    input wire logic serial_in,           // Bit entering at the top
    input wire logic [W-1:0] capture_val_in, // Parallel capture value
    output logic [W-1:0] data_out,        // Register contents
    output logic serial_out               // Bit leaving at the bottom
);
    logic [W-1:0] data_q;

    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            data_q <= '0;
        end else if (capture_in) begin
            data_q <= capture_val_in;
        end else if (shift_in) begin
            data_q <= {serial_in, data_q[W-1:1]}; // RULE3
        end
    end

    assign data_out = data_q;
    assign serial_out = data_q[0];

endmodule

// File: verilog/stap_top.sv
// Test access port: state controller, registers and output timing on the
// test clock, plus mode, disable and emulator pin handling on the system clock.
// Assumes the controller launches mode select and data relative to test clock.
`timescale 1ns/1ps
module stap_top #(
    parameter int USER_W = stap_pkg::STAP_USER_W
) (
    input wire logic clk_sys_in,          // System clock, 50 MHz
    input wire logic rst_b_in,            // System reset, active low
    input wire logic tck_in,              // Test clock from controller
    input wire logic test_rst_b_in,       // Test reset pin, low = functional
    input wire logic tms_in,              // Test mode select
    input wire logic tdi_in,              // Test data in
    output logic tdo_out,                 // Test data out value
    output logic tdo_oe_out,              // Test data out drive enable
    input wire logic emu_a_in,            // Emulator pin A level
    output logic emu_a_out,               // Emulator pin A drive value
    output logic emu_a_oe_out,            // Emulator pin A drive enable
    input wire logic emulator_pin_b_or_disable_in, // Pin B / disable level
    output logic emulator_pin_b_or_disable_out,    // Pin B drive value
    output logic emulator_pin_b_or_disable_oe_out, // Pin B drive enable
    input wire logic emu_a_drive_in,      // Core wants pin A pulled low
    input wire logic emu_b_drive_in,      // Core wants pin B pulled low
    output logic scan_mode_out,           // Scan system has control
    output logic outputs_off_out,         // Force all device drivers off
    output logic emu_a_event_out,         // Pin A seen low in scan mode
    output logic emu_b_event_out,         // Pin B seen low in scan mode
    output logic scan_active_out,         // Controller out of reset state
    output logic [stap_pkg::STAP_IR_W-1:0] instr_out, // Last updated instruction
    output logic instr_strobe_out,        // One-cycle pulse, new instruction
    output logic [USER_W-1:0] user_word_out, // Last updated user word
    output logic user_strobe_out          // One-cycle pulse, new user word
);
    import stap_pkg::*;

    // Test clock domain
    stap_state_t state_q;
    stap_state_t state_d;
    logic [STAP_IR_W-1:0] ir_q;
    logic [STAP_IR_W-1:0] ir_shift_data;
    logic ir_serial;
    logic [USER_W-1:0] user_shift_data;
    logic [USER_W-1:0] user_hold_q;
    logic user_serial;
    logic bypass_q;
    logic ir_tgl_q;
    logic dr_tgl_q;
    logic active_q;
    logic tdo_q;
    logic tdo_oe_q;
    logic sel_user;
    logic shifting;
    logic tdo_d;

    // System clock domain
    logic [STAP_SYNC_W-1:0] sync1_q;
    logic [STAP_SYNC_W-1:0] sync2_q;
    logic ir_tgl_prev_q;
    logic dr_tgl_prev_q;
    logic scan_mode_q;
    logic off_q;
    logic emu_a_event_q;
    logic emu_b_event_q;
    logic emu_a_oe_q;
    logic emu_b_oe_q;
    logic scan_active_q;
    logic [STAP_IR_W-1:0] instr_q;
    logic instr_strobe_q;
    logic [USER_W-1:0] user_word_q;
    logic user_strobe_q;
    logic off_d;

    // Next state from mode select; test reset low holds the reset state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            STAP_TLR: begin
                state_d = tms_in ? STAP_TLR : STAP_RTI; // RULE11
            end
            STAP_RTI: begin
                state_d = tms_in ? STAP_SEL_DR : STAP_RTI;
            end
            STAP_SEL_DR: begin
                state_d = tms_in ? STAP_SEL_IR : STAP_CAP_DR;
            end
            STAP_CAP_DR: begin
                state_d = tms_in ? STAP_EX1_DR : STAP_SH_DR;
            end
            STAP_SH_DR: begin
                state_d = tms_in ? STAP_EX1_DR : STAP_SH_DR;
            end
            STAP_EX1_DR: begin
                state_d = tms_in ? STAP_UPD_DR : STAP_PAU_DR;
            end
            STAP_PAU_DR: begin
                state_d = tms_in ? STAP_EX2_DR : STAP_PAU_DR;
            end
            STAP_EX2_DR: begin
                state_d = tms_in ? STAP_UPD_DR : STAP_SH_DR;
            end
            STAP_UPD_DR: begin
                state_d = tms_in ? STAP_SEL_DR : STAP_RTI;
            end
            STAP_SEL_IR: begin
                state_d = tms_in ? STAP_TLR : STAP_CAP_IR;
            end
            STAP_CAP_IR: begin
                state_d = tms_in ? STAP_EX1_IR : STAP_SH_IR;
            end
            STAP_SH_IR: begin
                state_d = tms_in ? STAP_EX1_IR : STAP_SH_IR;
            end
            STAP_EX1_IR: begin
                state_d = tms_in ? STAP_UPD_IR : STAP_PAU_IR;
            end
            STAP_PAU_IR: begin
                state_d = tms_in ? STAP_EX2_IR : STAP_PAU_IR;
            end
            STAP_EX2_IR: begin
                state_d = tms_in ? STAP_UPD_IR : STAP_SH_IR;
            end
            STAP_UPD_IR: begin
                state_d = tms_in ? STAP_SEL_DR : STAP_RTI;
            end
        endcase
    end

    // Test reset is the only reset of the test clock logic
    always_ff @(posedge tck_in or negedge test_rst_b_in) begin
        if (!test_rst_b_in) begin
            state_q <= STAP_TLR; // RULE11 RULE8
        end else begin
            state_q <= state_d; // RULE2 RULE7
        end
    end

    stap_shreg #(
        .W(STAP_IR_W)
    ) u_ir_shift (
        .clk_in(tck_in),
        .rst_b_in(test_rst_b_in),
        .capture_in(state_q == STAP_CAP_IR),
        .shift_in(state_q == STAP_SH_IR),
        .serial_in(tdi_in),
        .capture_val_in(STAP_IR_CAPTURE),
        .data_out(ir_shift_data),
        .serial_out(ir_serial)
    );

    assign sel_user = (ir_q == STAP_IR_USER);

    // User register captures its last update so software sees a loopback
    stap_shreg #(
        .W(USER_W)
    ) u_user_shift (
        .clk_in(tck_in),
        .rst_b_in(test_rst_b_in),
        .capture_in(sel_user && (state_q == STAP_CAP_DR)),
        .shift_in(sel_user && (state_q == STAP_SH_DR)),
        .serial_in(tdi_in),
        .capture_val_in(user_hold_q),
        .data_out(user_shift_data),
        .serial_out(user_serial)
    );

    // Instruction update; reset state forces bypass
    always_ff @(posedge tck_in or negedge test_rst_b_in) begin
        if (!test_rst_b_in) begin
            ir_q <= STAP_IR_BYPASS;
            ir_tgl_q <= 1'b0;
        end else if (state_q == STAP_TLR) begin
            ir_q <= STAP_IR_BYPASS;
        end else if (state_q == STAP_UPD_IR) begin
            ir_q <= ir_shift_data;
            ir_tgl_q <= ~ir_tgl_q;
        end
    end

    // Bypass stage for every code other than the user register
    always_ff @(posedge tck_in or negedge test_rst_b_in) begin
        if (!test_rst_b_in) begin
            bypass_q <= 1'b0;
        end else if (!sel_user && (state_q == STAP_CAP_DR)) begin
            bypass_q <= 1'b0;
        end else if (!sel_user && (state_q == STAP_SH_DR)) begin
            bypass_q <= tdi_in; // RULE3
        end
    end

    // Hold stays still for a whole scan, far longer than the sync delay
    always_ff @(posedge tck_in or negedge test_rst_b_in) begin
        if (!test_rst_b_in) begin
            user_hold_q <= '0;
            dr_tgl_q <= 1'b0;
        end else if (sel_user && (state_q == STAP_UPD_DR)) begin
            user_hold_q <= user_shift_data;
            dr_tgl_q <= ~dr_tgl_q;
        end
    end

    always_ff @(posedge tck_in or negedge test_rst_b_in) begin
        if (!test_rst_b_in) begin
            active_q <= 1'b0;
        end else begin
            active_q <= (state_d != STAP_TLR); // RULE11
        end
    end

    assign shifting = (state_q == STAP_SH_DR) || (state_q == STAP_SH_IR);

    always_comb begin
        tdo_d = 1'b0;
        if (state_q == STAP_SH_IR) begin
            tdo_d = ir_serial;
        end else if (state_q == STAP_SH_DR) begin
            tdo_d = sel_user ? user_serial : bypass_q;
        end
    end

    // Falling edge launch gives the controller half a period of setup.
    // Disable needs test reset low, which clears the enable at once.
    always_ff @(negedge tck_in or negedge test_rst_b_in) begin
        if (!test_rst_b_in) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0; // RULE6 RULE10
        end else begin
            tdo_q <= tdo_d; // RULE4
            tdo_oe_q <= shifting; // RULE5
        end
    end

    assign tdo_out = tdo_q;
    assign tdo_oe_out = tdo_oe_q;

    // Two-flop synchronisers for pins and test clock levels
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q[STAP_SY_IR_TGL] <= ir_tgl_q;
            sync1_q[STAP_SY_DR_TGL] <= dr_tgl_q;
            sync1_q[STAP_SY_ACTIVE] <= active_q;
            sync1_q[STAP_SY_TRST] <= test_rst_b_in;
            sync1_q[STAP_SY_EMU_A] <= emu_a_in;
            sync1_q[STAP_SY_EMU_B] <= emulator_pin_b_or_disable_in;
            sync2_q <= sync1_q;
        end
    end

    assign off_d = !sync2_q[STAP_SY_TRST] && sync2_q[STAP_SY_EMU_A]
        && !sync2_q[STAP_SY_EMU_B]; // RULE9

    // Mode, disable and controller-active levels
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            scan_mode_q <= 1'b0;
            off_q <= 1'b0;
            scan_active_q <= 1'b0;
        end else begin
            scan_mode_q <= sync2_q[STAP_SY_TRST]; // RULE7 RULE8
            off_q <= off_d; // RULE9 RULE10
            scan_active_q <= sync2_q[STAP_SY_ACTIVE];
        end
    end

    // Emulator pins act as interrupt lines only under scan control
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            emu_a_oe_q <= 1'b0;
            emu_b_oe_q <= 1'b0;
            emu_a_event_q <= 1'b0;
            emu_b_event_q <= 1'b0;
        end else begin
            emu_a_oe_q <= scan_mode_q && !off_q && emu_a_drive_in; // RULE10
            emu_b_oe_q <= scan_mode_q && !off_q && emu_b_drive_in; // RULE9
            emu_a_event_q <= scan_mode_q && !sync2_q[STAP_SY_EMU_A];
            emu_b_event_q <= scan_mode_q && !sync2_q[STAP_SY_EMU_B];
        end
    end

    // Toggle edges pick up words that are stable on the test side
    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            ir_tgl_prev_q <= 1'b0;
            instr_q <= STAP_IR_BYPASS;
            instr_strobe_q <= 1'b0;
        end else begin
            ir_tgl_prev_q <= sync2_q[STAP_SY_IR_TGL];
            instr_strobe_q <= sync2_q[STAP_SY_IR_TGL] ^ ir_tgl_prev_q;
            if (sync2_q[STAP_SY_IR_TGL] ^ ir_tgl_prev_q) begin
                instr_q <= ir_q;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            dr_tgl_prev_q <= 1'b0;
            user_word_q <= '0;
            user_strobe_q <= 1'b0;
        end else begin
            dr_tgl_prev_q <= sync2_q[STAP_SY_DR_TGL];
            user_strobe_q <= sync2_q[STAP_SY_DR_TGL] ^ dr_tgl_prev_q;
            if (sync2_q[STAP_SY_DR_TGL] ^ dr_tgl_prev_q) begin
                user_word_q <= user_hold_q;
            end
        end
    end

    // Pins are open-drain style: value low, enable decides
    assign emu_a_out = 1'b0;
    assign emulator_pin_b_or_disable_out = 1'b0;
    assign emu_a_oe_out = emu_a_oe_q;
    assign emulator_pin_b_or_disable_oe_out = emu_b_oe_q;
    assign scan_mode_out = scan_mode_q;
    assign outputs_off_out = off_q;
    assign emu_a_event_out = emu_a_event_q;
    assign emu_b_event_out = emu_b_event_q;
    assign scan_active_out = scan_active_q;
    assign instr_out = instr_q;
    assign instr_strobe_out = instr_strobe_q;
    assign user_word_out = user_word_q;
    assign user_strobe_out = user_strobe_q;

endmodule
